// *** hdl/dma_chan_status.sv ***
// DMA channel address/count registers, shared status and a simple transfer arbiter.
// Assumes requests and collision events come from logic on the same clock.
`timescale 1ns/1ns
module dma_chan_status (
  input wire logic ref_clk_i, // System clock, 20 MHz.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [11:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic [7:0] req_i, // Per-channel transfer requests.
  input wire logic [7:0] periph_col_i, // Peripheral write collision events.
  input wire logic [7:0] ram_col_i, // DMA RAM write collision events.
  output logic xfer_valid_o, // One transfer this cycle.
  output logic [2:0] xfer_chan_o, // Channel performing the transfer.
  output logic [15:0] xfer_ram_addr_o, // DMA RAM address of the transfer.
  output logic [15:0] xfer_periph_addr_o, // Peripheral address of the transfer.
  output logic xfer_dir_o, // 1 RAM to peripheral, 0 peripheral to RAM.
  output logic irq_o // Level interrupt, unmasked block-done pending.
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  dma_chan_pkg::chan_view_type view [dma_chan_pkg::NUM_CHAN];
  dma_chan_pkg::reg_write_type wreq;
  logic [7:0] chan_wr;
  logic [7:0] grant;
  logic [7:0] ready;
  logic [7:0] block_done;
  logic [7:0] pingpong_bits;
  logic [7:0] periph_col;
  logic [7:0] ram_col;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] col_clr_hi;
  logic [7:0] col_clr_lo;
  logic [7:0] irq_clr;
  logic [3:0] last_chan;
  logic [15:0] last_ram_address;
  logic [2:0] grant_idx;
  logic any_grant;
  logic bus_req;
  logic bus_wr;
  logic is_chan;
  logic is_shared;
  logic [2:0] reg_sel;
  logic [2:0] chan_sel;
  logic [15:0] wmask;
  logic [15:0] chan_rd;
  logic [15:0] shared_rd;
  logic [15:0] rd_word;
  logic ever_xfer;

  // --------------------------------------------------------------------------
  // Wishbone decode
  // --------------------------------------------------------------------------
  // Writes land on the edge where the master sees ack, so data is applied once.
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr = bus_req && wb_we_i && wb_ack_o;
  assign reg_sel = wb_adr_i[4:2];
  assign chan_sel = wb_adr_i[7:5];
  assign is_chan = (wb_adr_i[11:8] == 4'h0) && (wb_adr_i[1:0] == 2'h0);
  assign is_shared = ((wb_adr_i & ~12'h01C) == dma_chan_pkg::SHARED_BASE);
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wreq.reg_sel = reg_sel;
  assign wreq.data = wb_dat_i[15:0];
  assign wreq.mask = wmask;
  assign chan_wr = (bus_wr && is_chan) ? (8'h01 << chan_sel) : 8'h00;

  // Clears for the write-one-to-clear registers.
  assign col_clr_hi = (bus_wr && is_shared && (reg_sel == dma_chan_pkg::REG_COLLISION)) ?
    (wb_dat_i[15:8] & wmask[15:8]) : 8'h00;
  assign col_clr_lo = (bus_wr && is_shared && (reg_sel == dma_chan_pkg::REG_COLLISION)) ?
    (wb_dat_i[7:0] & wmask[7:0]) : 8'h00;
  assign irq_clr = (bus_wr && is_shared && (reg_sel == dma_chan_pkg::REG_IRQ_STATUS)) ?
    (wb_dat_i[7:0] & wmask[7:0]) : 8'h00;

  // --------------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------------
  // Peripheral address and count are rewritable while enabled; software must not.
  for (genvar n = 0; n < dma_chan_pkg::NUM_CHAN; n++) begin : g_chan
    chan_regs u_chan (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .wr_i(chan_wr[n]),
      .wreq_i(wreq),
      .xfer_i(grant[n]),
      .view_o(view[n]),
      .block_done_o(block_done[n])
    );
    assign ready[n] = view[n].enable && req_i[n];
    assign pingpong_bits[n] = view[n].pingpong;
  end

  // Fixed priority, channel 0 highest; one transfer per clock.
  assign grant = ready & (~ready + 8'h01);
  assign any_grant = (ready != 8'h00);
  assign grant_idx = grant[7] ? 3'h7 :
    grant[6] ? 3'h6 :
    grant[5] ? 3'h5 :
    grant[4] ? 3'h4 :
    grant[3] ? 3'h3 :
    grant[2] ? 3'h2 :
    grant[1] ? 3'h1 : 3'h0;

  // --------------------------------------------------------------------------
  // Sticky flags
  // --------------------------------------------------------------------------
  flag_bank #(.WIDTH(8)) u_periph_col (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .set_i(periph_col_i),
    .clr_i(col_clr_hi),
    .flags_o(periph_col)
  );
  flag_bank #(.WIDTH(8)) u_ram_col (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .set_i(ram_col_i),
    .clr_i(col_clr_lo),
    .flags_o(ram_col)
  );
  flag_bank #(.WIDTH(8)) u_irq (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .set_i(block_done),
    .clr_i(irq_clr),
    .flags_o(irq_status)
  );

  // --------------------------------------------------------------------------
  // Shared status
  // --------------------------------------------------------------------------
  // Last channel stays all ones until the first transfer ever.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_chan <= dma_chan_pkg::LAST_CHAN_NONE;
      last_ram_address <= dma_chan_pkg::ADDR_RESET;
      ever_xfer <= 1'b0;
    end else if (any_grant) begin
      last_chan <= {1'b0, grant_idx};
      last_ram_address <= view[grant_idx].ram_addr;
      ever_xfer <= 1'b1;
    end
  end

  // Mask register, low byte only.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask <= 8'h00;
    end else if (bus_wr && is_shared && (reg_sel == dma_chan_pkg::REG_IRQ_MASK)) begin
      irq_mask <= (irq_mask & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  // Unmapped addresses read as zero and still get an ack, so no master hangs.
  assign chan_rd =
    (reg_sel == dma_chan_pkg::REG_CTRL) ? {12'h000, view[chan_sel].mode,
      view[chan_sel].dir, view[chan_sel].enable} :
    (reg_sel == dma_chan_pkg::REG_PRIMARY) ? view[chan_sel].primary :
    (reg_sel == dma_chan_pkg::REG_SECONDARY) ? view[chan_sel].secondary :
    (reg_sel == dma_chan_pkg::REG_PERIPH) ? view[chan_sel].periph :
    (reg_sel == dma_chan_pkg::REG_COUNT) ? {6'h00, view[chan_sel].count} : 16'h0000;
  assign shared_rd =
    (reg_sel == dma_chan_pkg::REG_COLLISION) ? {periph_col, ram_col} :
    (reg_sel == dma_chan_pkg::REG_ACTIVITY) ? {4'h0, last_chan, pingpong_bits} :
    (reg_sel == dma_chan_pkg::REG_LAST_ADDR) ? last_ram_address :
    (reg_sel == dma_chan_pkg::REG_IRQ_STATUS) ? {8'h00, irq_status} :
    (reg_sel == dma_chan_pkg::REG_IRQ_MASK) ? {8'h00, irq_mask} : 16'h0000;
  assign rd_word = is_chan ? chan_rd : (is_shared ? shared_rd : 16'h0000);

  // Ack one cycle after the request, dropped the cycle after it was given.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= {16'h0000, rd_word};
    end
  end

  // --------------------------------------------------------------------------
  // Transfer outputs and interrupt
  // --------------------------------------------------------------------------
  // Registered so that every output comes straight from a flip-flop.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer_valid_o <= 1'b0;
      xfer_chan_o <= 3'h0;
      xfer_ram_addr_o <= 16'h0000;
      xfer_periph_addr_o <= 16'h0000;
      xfer_dir_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      xfer_valid_o <= any_grant;
      xfer_chan_o <= grant_idx;
      xfer_ram_addr_o <= view[grant_idx].ram_addr;
      xfer_periph_addr_o <= view[grant_idx].periph;
      xfer_dir_o <= view[grant_idx].dir;
      irq_o <= ((irq_status & irq_mask) != 8'h00);
    end
  end

  // Bus handshake and status bookkeeping.
  ack_single_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  last_none_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !ever_xfer |-> (last_chan == 4'hF))
    else $error("last channel left all ones before any transfer");
  last_chan_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    any_grant |=> (last_chan == {1'b0, xfer_chan_o}) && xfer_valid_o)
    else $error("last channel does not match transfer");
  last_addr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    xfer_valid_o |-> (last_ram_address == xfer_ram_addr_o))
    else $error("last address does not match transfer");
  dir_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    any_grant |=> (xfer_dir_o == view[xfer_chan_o].dir) || ($past(chan_wr) != 8'h00))
    else $error("transfer direction not taken from channel");

  // --------------------------------------------------------------------------
  // Further checks
  // --------------------------------------------------------------------------
  // Handshake: an ack only ever answers a pending request.
  ack_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wb_ack_o |-> $past(bus_req))
    else $error("ack without a request");
  ack_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !bus_req |=> !wb_ack_o)
    else $error("ack with no request pending");

  // Arbiter: one enabled requester wins, the lowest channel first.
  grant_onehot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    any_grant |-> $onehot(grant) && view[grant_idx].enable && req_i[grant_idx])
    else $error("grant is not one enabled requester");
  grant_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    any_grant |-> ((ready & ((8'h01 << grant_idx) - 8'h01)) == 8'h00))
    else $error("a lower ready channel was passed over");
  xfer_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !any_grant |=> !xfer_valid_o)
    else $error("transfer reported without a grant");
  xfer_chan_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    any_grant |=> xfer_valid_o && (xfer_chan_o == $past(grant_idx)))
    else $error("transfer channel differs from grant");

  // Status: the last channel and address move only with a transfer.
  last_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !any_grant |=> $stable(last_chan) && $stable(last_ram_address))
    else $error("last channel or address moved without a transfer");
  last_legal_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ever_xfer |-> !last_chan[3])
    else $error("last channel shows a reserved code");
  ram_col_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (col_clr_lo != 8'h00) |=> ((ram_col & $past(col_clr_lo) & ~$past(ram_col_i)) == 8'h00))
    else $error("RAM collision flag not cleared");
  periph_col_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (col_clr_hi != 8'h00) |=> ((periph_col & $past(col_clr_hi) & ~$past(periph_col_i)) == 8'h00))
    else $error("peripheral collision flag not cleared");

  // Interrupt: the level follows pending, unmasked status one cycle later.
  block_irq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (block_done != 8'h00) |=> ((irq_status & $past(block_done)) == $past(block_done)))
    else $error("block end not recorded in interrupt status");
  irq_raise_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ((irq_status & irq_mask) != 8'h00) |=> irq_o)
    else $error("interrupt not raised");
  irq_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ((irq_status & irq_mask) == 8'h00) |=> !irq_o)
    else $error("interrupt not dropped");
  mask_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !(bus_wr && is_shared && (reg_sel == dma_chan_pkg::REG_IRQ_MASK)) |=> $stable(irq_mask))
    else $error("mask changed without a write");

endmodule : dma_chan_status

// *** hdl/dma_chan_pkg.sv ***
// Shared constants and carriers for the DMA channel address and status block.
// Assumes a 32-bit classic Wishbone register bus and eight identical channels.
package dma_chan_pkg;

  // --------------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------------
  localparam int NUM_CHAN = 8;
  localparam int CHAN_BITS = 3;
  localparam int COUNT_BITS = 10;

  // --------------------------------------------------------------------------
  // Register word indexes and byte bases, channel group at channel * CHAN_STRIDE
  // --------------------------------------------------------------------------
  localparam logic [11:0] CHAN_STRIDE = 12'h020;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_PRIMARY = 3'h1;
  localparam logic [2:0] REG_SECONDARY = 3'h2;
  localparam logic [2:0] REG_PERIPH = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [11:0] SHARED_BASE = 12'h100;
  localparam logic [2:0] REG_COLLISION = 3'h0;
  localparam logic [2:0] REG_ACTIVITY = 3'h1;
  localparam logic [2:0] REG_LAST_ADDR = 3'h2;
  localparam logic [2:0] REG_IRQ_STATUS = 3'h3;
  localparam logic [2:0] REG_IRQ_MASK = 3'h4;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int MODE_ONE_SHOT_BIT = 0;
  localparam int MODE_PINGPONG_BIT = 1;
  localparam int PERIPH_COL_LSB = 8;
  localparam int RAM_COL_LSB = 0;
  localparam int LAST_CHAN_LSB = 8;
  localparam int PINGPONG_LSB = 0;
  localparam logic [3:0] LAST_CHAN_NONE = 4'hF;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [9:0] COUNT_RESET = 10'h000;

  // Per-channel programmed values and live state.
  typedef struct packed {
    logic enable;
    logic dir;
    logic [1:0] mode;
    logic pingpong;
    logic [15:0] primary;
    logic [15:0] secondary;
    logic [15:0] periph;
    logic [9:0] count;
    logic [15:0] ram_addr;
  } chan_view_type;

  // Bus write request fanned to every channel.
  typedef struct packed {
    logic [2:0] reg_sel;
    logic [15:0] data;
    logic [15:0] mask;
  } reg_write_type;

endpackage : dma_chan_pkg

// *** hdl/flag_bank.sv ***
// Bank of sticky flags, set by hardware events and cleared by writing ones.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ns
module flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_i, // System clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] set_i, // Event pulses, one per flag.
  input wire logic [WIDTH-1:0] clr_i, // Write-one-to-clear pulses.
  output logic [WIDTH-1:0] flags_o // Sticky flag values.
);

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~clr_i) | set_i;
    end
  end

  flag_set_wins_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
    else $error("flag event was lost");

endmodule : flag_bank

// *** hdl/chan_regs.sv ***
// One DMA channel: control, addresses, count and block sequencing.
// Assumes one transfer pulse per granted cycle from the arbiter above.
`timescale 1ns/1ns
module chan_regs (
  input wire logic ref_clk_i, // System clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic wr_i, // Register write for this channel.
  input wire dma_chan_pkg::reg_write_type wreq_i, // Write select, data and mask.
  input wire logic xfer_i, // This channel moves one item this cycle.
  output dma_chan_pkg::chan_view_type view_o, // Programmed and live values.
  output logic block_done_o // Last transfer of a block, one cycle.
);

  logic [15:0] ctrl_word;
  logic [15:0] primary;
  logic [15:0] secondary;
  logic [15:0] periph;
  logic [9:0] count;
  logic [9:0] index;
  logic pingpong;
  logic wr_ctrl;
  logic one_shot_stop;
  logic [1:0] mode;
  logic [15:0] count_merge;
  logic [15:0] ctrl_merge;

  // --------------------------------------------------------------------------
  // Decode and merge
  // --------------------------------------------------------------------------
  // Byte lanes that are not selected keep their old contents.
  assign wr_ctrl = wr_i && (wreq_i.reg_sel == dma_chan_pkg::REG_CTRL);
  assign ctrl_merge = (ctrl_word & ~wreq_i.mask) | (wreq_i.data & wreq_i.mask);
  assign count_merge = ({6'h00, count} & ~wreq_i.mask) | (wreq_i.data & wreq_i.mask);
  assign mode = ctrl_word[dma_chan_pkg::CTRL_MODE_LSB +: 2];
  assign block_done_o = xfer_i && (index == count);
  // One-shot ends after one block, or after both buffers when alternating.
  assign one_shot_stop = block_done_o && mode[dma_chan_pkg::MODE_ONE_SHOT_BIT] &&
    (!mode[dma_chan_pkg::MODE_PINGPONG_BIT] || pingpong);

  // Programmed registers, all zero after reset.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_word <= 16'h0000;
      primary <= dma_chan_pkg::ADDR_RESET;
      secondary <= dma_chan_pkg::ADDR_RESET;
      periph <= dma_chan_pkg::ADDR_RESET;
      count <= dma_chan_pkg::COUNT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_word <= ctrl_merge & 16'h000F;
      end else if (one_shot_stop) begin
        ctrl_word[dma_chan_pkg::CTRL_ENABLE_BIT] <= 1'b0;
      end
      if (wr_i && (wreq_i.reg_sel == dma_chan_pkg::REG_PRIMARY)) begin
        primary <= (primary & ~wreq_i.mask) | (wreq_i.data & wreq_i.mask);
      end
      if (wr_i && (wreq_i.reg_sel == dma_chan_pkg::REG_SECONDARY)) begin
        secondary <= (secondary & ~wreq_i.mask) | (wreq_i.data & wreq_i.mask);
      end
      if (wr_i && (wreq_i.reg_sel == dma_chan_pkg::REG_PERIPH)) begin
        periph <= (periph & ~wreq_i.mask) | (wreq_i.data & wreq_i.mask);
      end
      if (wr_i && (wreq_i.reg_sel == dma_chan_pkg::REG_COUNT)) begin
        count <= count_merge[9:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Block sequencing
  // --------------------------------------------------------------------------
  // Rewriting control restarts the block at the primary buffer.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      index <= 10'h000;
      pingpong <= 1'b0;
    end else if (wr_ctrl) begin
      index <= 10'h000;
      pingpong <= 1'b0;
    end else if (block_done_o) begin
      index <= 10'h000;
      if (mode[dma_chan_pkg::MODE_PINGPONG_BIT]) begin
        pingpong <= ~pingpong;
      end
    end else if (xfer_i) begin
      index <= index + 10'h001;
    end
  end

  // Post-incremented address into the buffer now selected.
  assign view_o.enable = ctrl_word[dma_chan_pkg::CTRL_ENABLE_BIT];
  assign view_o.dir = ctrl_word[dma_chan_pkg::CTRL_DIR_BIT];
  assign view_o.mode = mode;
  assign view_o.pingpong = pingpong;
  assign view_o.primary = primary;
  assign view_o.secondary = secondary;
  assign view_o.periph = periph;
  assign view_o.count = count;
  assign view_o.ram_addr = (pingpong ? secondary : primary) + {6'h00, index};

  block_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (block_done_o && !wr_ctrl) |=> (index == 10'h000))
    else $error("index did not wrap at block end");
  pingpong_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (block_done_o && !wr_ctrl && mode[1]) |=> (pingpong != $past(pingpong)))
    else $error("ping-pong did not toggle at block end");
  one_shot_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (one_shot_stop && !wr_ctrl) |=> !view_o.enable)
    else $error("one-shot channel stayed enabled");

endmodule : chan_regs

// *** test/periph_model.sv ***
// Behavioural peripheral side: holds one channel's request level for a set number of items.
// Assumes the block takes one item for each cycle the request is high.
`timescale 1ns/1ns
module periph_model (
  input wire logic ref_clk_i, // System clock.
  input wire logic rst_b_i, // Reset, active low.
  input wire logic [2:0] chan_i, // Channel to serve.
  input wire logic [3:0] items_i, // Items wanted, loaded by go.
  input wire logic go_i, // Start pulse.
  input wire logic stall_i, // Slow peripheral, request withdrawn.
  output logic [7:0] req_o // Request levels.
);
  logic [3:0] left;
  // Each high cycle is one item, so a stall must hold the count as well as the level.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) left <= 4'h0;
    else if (go_i) left <= items_i;
    else if (left != 4'h0 && !stall_i) left <= left - 4'h1;
  end
  assign req_o = (left != 4'h0 && !stall_i) ? (8'h01 << chan_i) : 8'h00;
endmodule : periph_model

// *** test/tb_dma_chan_status.sv ***
// Self-checking bench for the DMA channel address and status block.
// Assumes the register map and one-cycle answers stated for the design.
`timescale 1ns/1ns
module tb_dma_chan_status;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cyc = 1'b0, we = 1'b0, go = 1'b0, stall = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic wb_ack_o, xfer_valid_o, xfer_dir_o, irq_o;
  logic [2:0] xfer_chan_o, pchan = 3'h0;
  logic [3:0] items = 4'h0, sel = 4'h3;
  logic [15:0] xfer_ram_addr_o, xfer_periph_addr_o, pa, sa, pd;
  logic [7:0] req, pcol = 8'h00, rcol = 8'h00;
  logic [31:0] seen[$];
  logic [15:0] pseen[$];
  int bad_count = 0, comparisons = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  dma_chan_status u_dut (.ref_clk_i, .rst_b_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .req_i(req),
    .periph_col_i(pcol), .ram_col_i(rcol), .xfer_valid_o, .xfer_chan_o, .xfer_ram_addr_o,
    .xfer_periph_addr_o, .xfer_dir_o, .irq_o);
  periph_model u_periph (.ref_clk_i, .rst_b_i, .chan_i(pchan), .items_i(items), .go_i(go),
    .stall_i(stall), .req_o(req));
  // Every transfer is logged so order and addresses can be compared afterwards.
  always @(posedge ref_clk_i) if (xfer_valid_o === 1'b1) begin
    seen.push_back({12'h0, xfer_dir_o, xfer_chan_o, xfer_ram_addr_o});
    pseen.push_back(xfer_periph_addr_o);
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One classic cycle; the wait is bounded so a silent slave cannot hang the run.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h0, 32'h1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, rdat, exp);
  endtask : rd
  // The peripheral withdraws for one cycle after go, before its first item, to exercise a slow far side.
  task automatic serve(input logic [2:0] ch, input logic [3:0] n);
    @(posedge ref_clk_i);
    pchan <= ch;
    items <= n;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    stall <= 1'b1;
    @(posedge ref_clk_i);
    stall <= 1'b0;
    repeat (int'(n) + 4) @(posedge ref_clk_i);
  endtask : serve
  task automatic blk(input logic [15:0] base, input logic dir, input logic [2:0] ch, input int n);
    for (int k = 0; k < n; k++) begin
      chk("xfer", seen.pop_front(), {12'h0, dir, ch, base + 16'(k)});
      chk("xfer_periph", {16'h0, pseen.pop_front()}, {16'h0, pd});
    end
  endtask : blk
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end
  initial begin
    logic [31:0] r;
    logic [11:0] a;
    r = $urandom(60756);
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(12'h104, 32'h0000_0F00, "activity_reset");
    rd(12'h108, 32'h0, "last_addr_reset");
    for (int c = 0; c < 8; c++) begin
      for (int k = 1; k < 5; k++) begin
        r = $urandom;
        a = 12'(c * 32 + k * 4);
        rd(a, 32'h0, "reg_reset");
        bus(1'b1, a, r);
        rd(a, (k == 4) ? {22'h0, r[9:0]} : {16'h0, r[15:0]}, "reg_rw");
      end
    end
    bus(1'b1, 12'h1FC, 32'hFFFF);
    rd(12'h1FC, 32'h0, "unmapped");
    // Only the selected low byte lane may change.
    bus(1'b1, 12'h0EC, 32'h1234);
    sel <= 4'h1;
    bus(1'b1, 12'h0EC, 32'hFFFF);
    sel <= 4'h3;
    rd(12'h0EC, 32'h12FF, "byte_lane");
    r = $urandom | 32'h0000_8001;
    pcol <= r[15:8];
    rcol <= r[7:0];
    @(posedge ref_clk_i);
    pcol <= 8'h00;
    rcol <= 8'h00;
    rd(12'h100, {16'h0, r[15:0]}, "collisions");
    bus(1'b1, 12'h100, r);
    rd(12'h100, 32'h0, "collisions_clr");
    pa = 16'($urandom);
    sa = 16'($urandom);
    pd = 16'($urandom);
    bus(1'b1, 12'h064, {16'h0, pa});
    bus(1'b1, 12'h068, {16'h0, sa});
    bus(1'b1, 12'h06C, {16'h0, pd});
    bus(1'b1, 12'h070, 32'h1);
    bus(1'b1, 12'h060, 32'h0000_000B);
    serve(3'h3, 4'h2);
    blk(pa, 1'b1, 3'h3, 2);
    rd(12'h104, 32'h0000_0308, "activity");
    rd(12'h108, {16'h0, pa + 16'h1}, "last_addr");
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    bus(1'b1, 12'h110, 32'h8);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_on", {31'h0, irq_o}, 32'h1);
    bus(1'b1, 12'h10C, 32'h8);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_off", {31'h0, irq_o}, 32'h0);
    serve(3'h3, 4'h2);
    blk(sa, 1'b1, 3'h3, 2);
    rd(12'h104, 32'h0000_0300, "activity_pp");
    // One-shot with ping-pong: one item from each buffer, then the channel stops.
    bus(1'b1, 12'h0C4, {16'h0, pa});
    bus(1'b1, 12'h0C8, {16'h0, sa});
    bus(1'b1, 12'h0CC, {16'h0, pd});
    bus(1'b1, 12'h0D0, 32'h0);
    bus(1'b1, 12'h0C0, 32'h0000_000F);
    serve(3'h6, 4'h4);
    blk(pa, 1'b1, 3'h6, 1);
    blk(sa, 1'b1, 3'h6, 1);
    rd(12'h0C0, 32'h0000_000E, "oneshot_pp");
    bus(1'b1, 12'h0A4, {16'h0, pa});
    bus(1'b1, 12'h0AC, {16'h0, pd});
    bus(1'b1, 12'h0B0, 32'h0);
    bus(1'b1, 12'h0A0, 32'h0000_0005);
    serve(3'h5, 4'h3);
    blk(pa, 1'b0, 3'h5, 1);
    chk("oneshot_left", 32'(seen.size()), 32'h0);
    rd(12'h0A0, 32'h0000_0004, "oneshot_ctrl");
    serve(3'h0, 4'h2);
    chk("disabled", 32'(seen.size()), 32'h0);
    rd(12'h104, 32'h0000_0500, "activity_last");
    stop_test();
  end
endmodule : tb_dma_chan_status
